// [src/ssc_top.sv]
// supply supervision control: checkers, brownout hold, regulator mode, axi4-lite registers
`timescale 1ns/1ps
module ssc_top #(
	parameter int ADDR_W = 4
) (
	input  wire logic              aclk,              // 100 MHz system clock
	input  wire logic              aresetn,           // brownout reset, sync, low
	// axi4-lite slave
	input  wire logic              awvalid,           // write address valid
	output      logic              awready,           // write address ready
	input  wire logic [ADDR_W-1:0] awaddr,            // write byte address
	input  wire logic              wvalid,            // write data valid
	output      logic              wready,            // write data ready
	input  wire logic [31:0]       wdata,             // write data
	input  wire logic [3:0]        wstrb,             // write byte enables
	output      logic              bvalid,            // write response valid
	input  wire logic              bready,            // write response ready
	output      logic [1:0]        bresp,             // write response
	input  wire logic              arvalid,           // read address valid
	output      logic              arready,           // read address ready
	input  wire logic [ADDR_W-1:0] araddr,            // read byte address
	output      logic              rvalid,            // read data valid
	input  wire logic              rready,            // read data ready
	output      logic [31:0]       rdata,             // read data
	output      logic [1:0]        rresp,             // read response
	// analogue comparators, asynchronous
	input  wire logic [3:0]        below_raw,         // per checker supply below level
	input  wire logic              core_below_brownout, // core below brownout preset
	input  wire logic              core_ready,        // core fit for default clock
	// activity, same clock domain
	input  wire logic              cpu_active,        // cpu running
	input  wire logic              low_power_mode_0,  // cpu in low power mode 0
	input  wire logic              low_power_mode_1,  // cpu in low power mode 1
	input  wire logic              fast_clock_in_use, // a module uses a clock above 32 kHz
	input  wire logic              irq_executing,     // interrupt being serviced
	// to analogue and reset network
	output      logic [1:0]        core_level_select, // regulator step
	output      logic [3:0]        checker_enable,    // per checker enable
	output      logic [2:0]        high_sup_level,    // input supervisor threshold now
	output      logic [2:0]        high_mon_level,    // input monitor threshold
	output      logic [2:0]        low_sup_level,     // core supervisor threshold now
	output      logic [2:0]        low_mon_level,     // core monitor threshold
	output      logic              high_current_mode, // regulator load mode
	output      logic              por_request,       // power-on reset request
	output      logic              device_reset_n,    // brownout device reset, low
	output      logic              high_monitor_irq   // input monitor interrupt request
);
	import ssc_pkg::*;

	// ===========================================================
	// helpers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [2:0] low_rel(input logic [2:0] code);
		return (code > LOW_REL_TOP) ? LOW_REL_TOP : code;
	endfunction : low_rel

	// ===========================================================
	// registers
	logic [9:0]        ctrl_q;
	logic [8:0]        hcfg_q;
	logic [8:0]        lcfg_q;
	logic [3:0]        flag_q;
	logic [3:0]        flag_d;
	logic [SYN_W-1:0]  s1_q;
	logic [SYN_W-1:0]  s2_q;
	logic [SYN_W-1:0]  s3_q;
	logic [SYN_W-1:0]  filt_q;
	logic [SYN_W-1:0]  filt_d;
	logic              hcur_q;
	logic              por_q;
	logic              devrst_n_q;
	logic              irq_q;
	logic              aw_have_q;
	logic              w_have_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;

	// ===========================================================
	// comparator synchronisers
	wire [SYN_W-1:0] raw_in = {core_ready, core_below_brownout, below_raw};

	// a level counts only once the second and third stages agree
	assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q   <= SYNC_RESET;
			s2_q   <= SYNC_RESET;
			s3_q   <= SYNC_RESET;
			filt_q <= SYNC_RESET;
		end else begin
			s1_q   <= raw_in;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= filt_d;
		end
	end

	// ===========================================================
	// checkers
	wire [3:0] enables = {ctrl_q[LMON_EN_BIT], ctrl_q[LSUP_EN_BIT],
	                      ctrl_q[HMON_EN_BIT], ctrl_q[HSUP_EN_BIT]};
	// each checker acts on its own, all four at once
	wire [3:0] trip    = enables & filt_q[3:0];
	wire       do_wr   = aw_have_q && w_have_q && !bvalid_q;
	wire       stat_wr = do_wr && (awaddr_q[3:0] == ADDR_STAT);
	wire [3:0] clr     = stat_wr ? (wdata_q[FLAG_LSB +: 4] & {4{wstrb_q[0]}}) : 4'h0;

	// a trip in the clearing cycle still sets the flag
	assign flag_d = (flag_q & ~clr) | trip;

	// only supervisors may raise por_request; monitors never do
	wire por_d = (trip[CHK_HSUP] && ctrl_q[HSUP_RST_BIT]) ||
	             (trip[CHK_LSUP] && ctrl_q[LSUP_RST_BIT]);
	wire mon_irq_d = flag_d[CHK_HMON] && hcfg_q[HMON_IE_BIT];

	// ===========================================================
	// regulator load and brownout
	wire hcur_d = cpu_active || low_power_mode_0 || low_power_mode_1 ||
	              fast_clock_in_use || irq_executing;
	wire devrst_n_d = filt_q[SYN_RDY] && !filt_q[SYN_BROWN];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q     <= 4'h0;
			por_q      <= 1'b0;
			irq_q      <= 1'b0;
			hcur_q     <= 1'b1;
			devrst_n_q <= 1'b0;
		end else begin
			flag_q     <= flag_d;
			por_q      <= por_d;
			irq_q      <= mon_irq_d;
			hcur_q     <= hcur_d;
			devrst_n_q <= devrst_n_d;
		end
	end

	// ===========================================================
	// thresholds: supervisors switch to release level while below
	wire [1:0] h_rst = hcfg_q[RST_LVL_LSB +: 2];
	wire [2:0] h_rel = hcfg_q[REL_LVL_LSB +: 3];
	wire [1:0] l_rst = lcfg_q[RST_LVL_LSB +: 2];
	wire [2:0] l_rel = low_rel(lcfg_q[REL_LVL_LSB +: 3]);

	assign high_sup_level = filt_q[CHK_HSUP] ? h_rel : {1'b0, h_rst};
	assign low_sup_level  = filt_q[CHK_LSUP] ? l_rel : {1'b0, l_rst};
	assign high_mon_level = h_rel;
	assign low_mon_level  = l_rel;

	// ===========================================================
	// axi4-lite write path: address and data taken in either order
	assign awready = !aw_have_q && !bvalid_q;
	assign wready  = !w_have_q && !bvalid_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;

	wire wr_ctrl = do_wr && (awaddr_q[3:0] == ADDR_CTRL);
	wire wr_hcfg = do_wr && (awaddr_q[3:0] == ADDR_HCFG);
	wire wr_lcfg = do_wr && (awaddr_q[3:0] == ADDR_LCFG);
	wire wr_ok   = wr_ctrl || wr_hcfg || wr_lcfg || stat_wr;

	wire [31:0] ctrl_m = merge({22'h0, ctrl_q}, wdata_q, wstrb_q);
	wire [31:0] hcfg_m = merge({23'h0, hcfg_q}, wdata_q, wstrb_q);
	wire [31:0] lcfg_m = merge({23'h0, lcfg_q}, wdata_q, wstrb_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= awaddr;
			end
			if (wvalid && wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= wdata;
				wstrb_q  <= wstrb;
			end
			if (do_wr) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// defaults: level 00, every checker and supervisor reset on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
			hcfg_q <= HCFG_RESET;
			lcfg_q <= LCFG_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= ctrl_m[9:0] & CTRL_MASK;
			end
			if (wr_hcfg) begin
				hcfg_q <= hcfg_m[8:0] & HCFG_MASK;
			end
			if (wr_lcfg) begin
				lcfg_q <= lcfg_m[8:0] & LCFG_MASK;
			end
		end
	end

	// ===========================================================
	// axi4-lite read path
	wire [3:0] ra = araddr[3:0];
	wire [31:0] stat_word = {18'h0, devrst_n_q, hcur_q,
	                         filt_q[3:0], 4'h0, flag_q};
	wire [31:0] rd_mux = (ra == ADDR_CTRL) ? {22'h0, ctrl_q} :
	                     (ra == ADDR_HCFG) ? {23'h0, hcfg_q} :
	                     (ra == ADDR_LCFG) ? {23'h0, lcfg_q} :
	                     (ra == ADDR_STAT) ? stat_word : 32'h0;
	wire rd_hit = (ra == ADDR_CTRL) || (ra == ADDR_HCFG) ||
	              (ra == ADDR_LCFG) || (ra == ADDR_STAT);

	assign arready = !rvalid_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ===========================================================
	// outputs
	assign core_level_select = ctrl_q[CORE_LVL_LSB +: 2];
	assign checker_enable    = enables;
	assign high_current_mode = hcur_q;
	assign por_request       = por_q;
	assign device_reset_n    = devrst_n_q;
	assign high_monitor_irq  = irq_q;

	// ===========================================================
	// assertions
	sequence clear_hsup_s;
		stat_wr && clr[CHK_HSUP];
	endsequence

	sequence hsup_trip_s;
		trip[CHK_HSUP] && ctrl_q[HSUP_RST_BIT];
	endsequence

	level_reset_a: assert property (@(posedge aclk)
		!aresetn |=> core_level_select == 2'h0)
		else $error("core level not 00 after reset");

	enable_reset_a: assert property (@(posedge aclk)
		!aresetn |=> (checker_enable == 4'hf) && ctrl_q[LSUP_RST_BIT])
		else $error("checkers or reset enable not on after reset");

	sup_por_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hsup_trip_s |=> por_request)
		else $error("supervisor trip gave no reset request");

	mon_no_por_a: assert property (@(posedge aclk) disable iff (!aresetn)
		por_request |-> $past(trip[CHK_HSUP] || trip[CHK_LSUP]))
		else $error("reset request without supervisor trip");

	set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clear_hsup_s ##0 trip[CHK_HSUP] |=> flag_q[CHK_HSUP])
		else $error("clear won over a trip");

	flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(flag_q[CHK_LMON] && !clr[CHK_LMON]) |=> flag_q[CHK_LMON])
		else $error("flag dropped without a clear");

	mon_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(flag_q[CHK_HMON]) && hcfg_q[HMON_IE_BIT] |-> high_monitor_irq)
		else $error("monitor flag with enable gave no interrupt");

	reg_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aresetn && !hcur_d |=> !high_current_mode)
		else $error("regulator left in high current without demand");

	reg_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hcur_d |=> high_current_mode)
		else $error("regulator not in high current under demand");

	brownout_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(filt_q[SYN_BROWN] || !filt_q[SYN_RDY]) |=> !device_reset_n)
		else $error("device released while core supply short");

	release_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		low_mon_level <= LOW_REL_TOP)
		else $error("core release level above top code");

	hyst_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		filt_q[CHK_LSUP] |-> low_sup_level == l_rel)
		else $error("core supervisor not on release level while below");

	sync_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(filt_q[CHK_HSUP]) |-> $past(s3_q[CHK_HSUP]) == filt_q[CHK_HSUP])
		else $error("comparator level used before agreement");

	// a disabled input supervisor must stay silent while the core one is quiet
	sup_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!checker_enable[CHK_HSUP] && !trip[CHK_LSUP] |=> !por_request)
		else $error("disabled supervisor gave a reset request");

	irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		high_monitor_irq |-> $past(hcfg_q[HMON_IE_BIT]))
		else $error("monitor interrupt without its enable");

endmodule : ssc_top

// [src/ssc_pkg.sv]
// constants for the supply supervision control block
// ===========================================================
package ssc_pkg;

	// ===========================================================
	// register map
	localparam logic [3:0]  ADDR_CTRL = 4'h0;
	localparam logic [3:0]  ADDR_HCFG = 4'h4;
	localparam logic [3:0]  ADDR_LCFG = 4'h8;
	localparam logic [3:0]  ADDR_STAT = 4'hc;

	// ===========================================================
	// control field positions
	localparam int CORE_LVL_LSB  = 0;
	localparam int HSUP_EN_BIT   = 4;
	localparam int HMON_EN_BIT   = 5;
	localparam int LSUP_EN_BIT   = 6;
	localparam int LMON_EN_BIT   = 7;
	localparam int HSUP_RST_BIT  = 8;
	localparam int LSUP_RST_BIT  = 9;
	localparam logic [9:0] CTRL_RESET = 10'h3f0;
	localparam logic [9:0] CTRL_MASK  = 10'h3f3;

	// ===========================================================
	// threshold configuration fields; level fields shared by both sides, interrupt enable on the input side only
	localparam int RST_LVL_LSB   = 0;
	localparam int REL_LVL_LSB   = 4;
	localparam int HMON_IE_BIT   = 8;
	localparam logic [8:0] HCFG_RESET = 9'h000;
	localparam logic [8:0] HCFG_MASK  = 9'h173;
	localparam logic [8:0] LCFG_RESET = 9'h000;
	localparam logic [8:0] LCFG_MASK  = 9'h073;
	localparam logic [2:0] LOW_REL_TOP = 3'h3;

	// ===========================================================
	// status fields
	localparam int FLAG_LSB      = 0;
	localparam int LIVE_LSB      = 8;
	localparam int HCUR_BIT      = 12;
	localparam int DEVRST_BIT    = 13;

	// ===========================================================
	// checker index and synchroniser layout
	localparam int CHK_HSUP = 0;
	localparam int CHK_HMON = 1;
	localparam int CHK_LSUP = 2;
	localparam int CHK_LMON = 3;
	localparam int SYN_BROWN = 4;
	localparam int SYN_RDY  = 5;
	localparam int SYN_W    = 6;
	localparam logic [5:0] SYNC_RESET = 6'h10;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ssc_pkg

// [dv/ssc_ana_model.sv]
// behavioural model of the analogue comparators and brownout detector
`timescale 1ns/1ps
module ssc_ana_model (
	input  wire logic [2:0] hi_v,           // input supply, threshold code units
	input  wire logic [2:0] lo_v,           // core supply, threshold code units
	input  wire logic [2:0] high_sup_level, // input supervisor threshold
	input  wire logic [2:0] high_mon_level, // input monitor threshold
	input  wire logic [2:0] low_sup_level,  // core supervisor threshold
	input  wire logic [2:0] low_mon_level,  // core monitor threshold
	output      logic [3:0] below_raw,      // per checker supply below level
	output      logic       core_below_brownout, // core below brownout preset
	output      logic       core_ready      // core fit for default clock
);
	// ===========================================================
	// comparators
	// comparators run whether or not a checker is enabled, as the real ones may
	assign below_raw      = {lo_v < low_mon_level, lo_v < low_sup_level,
	                         hi_v < high_mon_level, hi_v < high_sup_level};
	// code 0 stands for a core rail under the preset
	assign core_below_brownout = (lo_v == 3'h0);
	assign core_ready     = (lo_v != 3'h0);
endmodule : ssc_ana_model

// [dv/tb_supply_supervision_control.sv]
// self-checking bench for the supply supervision control block
`timescale 1ns/1ps
module tb_supply_supervision_control;
	import ssc_pkg::*;
	typedef struct packed {logic [4:0] act; logic hc;} ssc_row_s;

	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [3:0] awaddr, araddr, wstrb, below_raw, checker_enable;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, core_level_select, rs;
	logic awready, wready, bvalid, arready, rvalid;
	logic core_below_brownout, core_ready, high_current_mode, por_request;
	logic device_reset_n, high_monitor_irq;
	logic cpu_active, low_power_mode_0, low_power_mode_1, fast_clock_in_use, irq_executing;
	logic [2:0] hi_v, lo_v, high_sup_level, high_mon_level, low_sup_level, low_mon_level;
	int err_count = 0;
	int tests_run = 0;
	ssc_row_s rows [6] = '{'{5'h10, 1'b1}, '{5'h08, 1'b1}, '{5'h04, 1'b1},
	                       '{5'h02, 1'b1}, '{5'h01, 1'b1}, '{5'h00, 1'b0}};

	ssc_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .below_raw(below_raw),
		.core_below_brownout(core_below_brownout), .core_ready(core_ready),
		.cpu_active(cpu_active), .low_power_mode_0(low_power_mode_0),
		.low_power_mode_1(low_power_mode_1), .fast_clock_in_use(fast_clock_in_use),
		.irq_executing(irq_executing), .core_level_select(core_level_select),
		.checker_enable(checker_enable), .high_sup_level(high_sup_level),
		.high_mon_level(high_mon_level), .low_sup_level(low_sup_level),
		.low_mon_level(low_mon_level), .high_current_mode(high_current_mode),
		.por_request(por_request), .device_reset_n(device_reset_n),
		.high_monitor_irq(high_monitor_irq));

	ssc_ana_model ana (.hi_v(hi_v), .lo_v(lo_v), .high_sup_level(high_sup_level),
		.high_mon_level(high_mon_level), .low_sup_level(low_sup_level),
		.low_mon_level(low_mon_level), .below_raw(below_raw),
		.core_below_brownout(core_below_brownout), .core_ready(core_ready));

	// ===========================================================
	// clock and watchdog
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		#300us;
		err_count++;
		test_done();
	end

	// ===========================================================
	// helpers
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// flag path is 3 sync edges plus filter plus flag or output register
	task settle;
		repeat (8) @(posedge aclk);
	endtask : settle

	task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [3:0] a);
		@(posedge aclk);
		arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task test_done;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	// ===========================================================
	// stimulus
	initial begin
		aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
		rready = 1'b0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'h0;
		{cpu_active, low_power_mode_0, low_power_mode_1, fast_clock_in_use, irq_executing} = 5'h10;
		hi_v = 3'h7;
		lo_v = 3'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		// power-up: core still under the preset, device must stay held
		settle();
		chk(device_reset_n, 1'b0);
		axi_rd(ADDR_CTRL); chk(rd, 32'h3f0);
		axi_rd(ADDR_HCFG); chk(rd, 32'h0);
		axi_rd(ADDR_LCFG); chk(rd, 32'h0);
		axi_rd(ADDR_STAT);
		chk(rd, 32'h1 << HCUR_BIT);
		chk(checker_enable, 4'hf);
		lo_v <= 3'h3;
		settle();
		chk(device_reset_n, 1'b1);
		axi_rd(ADDR_STAT);
		chk(rd, (32'h1 << HCUR_BIT) | (32'h1 << DEVRST_BIT));
		$display("test reset done");

		foreach (rows[i]) begin
			@(posedge aclk);
			{cpu_active, low_power_mode_0, low_power_mode_1, fast_clock_in_use,
			 irq_executing} <= rows[i].act;
			repeat (3) @(posedge aclk);
			chk(high_current_mode, rows[i].hc);
		end
		$display("test regulator mode done");

		// core release level capped at code 3
		axi_wr(ADDR_HCFG, 32'h132, 4'hf);
		chk(rs, RESP_OKAY);
		for (int c = 0; c < 8; c++) begin
			axi_wr(ADDR_LCFG, c << 4, 4'hf);
			chk(low_mon_level, (c > 3) ? 3 : c);
		end
		axi_wr(ADDR_LCFG, 32'h32, 4'hf);
		chk(high_mon_level, 3'h3);
		chk(high_sup_level, 3'h2);
		chk(low_sup_level, 3'h2);
		$display("test thresholds done");

		// between supervisor and monitor thresholds: flag and irq, no reset
		hi_v <= 3'h2;
		settle();
		chk(por_request, 1'b0);
		chk(high_monitor_irq, 1'b1);
		hi_v <= 3'h1;
		settle();
		chk(por_request, 1'b1);
		chk(high_sup_level, 3'h3);
		axi_wr(ADDR_STAT, 32'hf, 4'h1);
		axi_rd(ADDR_STAT); chk(rd[3:0], 4'h3);
		hi_v <= 3'h7;
		settle();
		chk(por_request, 1'b0);
		axi_rd(ADDR_STAT); chk(rd[3:0], 4'h3);
		axi_wr(ADDR_STAT, 32'hf, 4'h1);
		axi_rd(ADDR_STAT); chk(rd[3:0], 4'h0);
		settle();
		chk(high_monitor_irq, 1'b0);
		$display("test input side done");

		hi_v <= 3'h1;
		lo_v <= 3'h1;
		settle();
		axi_rd(ADDR_STAT); chk(rd[3:0], 4'hf);
		chk(rd[11:8], 4'hf);
		hi_v <= 3'h7;
		lo_v <= 3'h3;
		settle();
		axi_wr(ADDR_STAT, 32'hf, 4'h1);
		axi_rd(ADDR_STAT); chk(rd[3:0], 4'h0);
		$display("test concurrent done");

		// level raised to 3 and input supervisor disabled: its trip must give no reset
		axi_wr(ADDR_CTRL, 32'h3e3, 4'hf);
		chk(core_level_select, 2'h3);
		chk(checker_enable, 4'he);
		hi_v <= 3'h1;
		settle();
		chk(por_request, 1'b0);
		axi_rd(4'h2); chk(rs, RESP_SLVERR);
		$display("test disable done");

		lo_v <= 3'h0;
		settle();
		chk(device_reset_n, 1'b0);
		$display("test brownout done");

		// flags stay set until the reset network pulls aresetn
		hi_v <= 3'h7;
		lo_v <= 3'h3;
		settle();
		axi_rd(ADDR_STAT);
		chk(rd[3:0], 4'he);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(core_level_select, 2'h0);
		chk(checker_enable, 4'hf);
		axi_rd(ADDR_STAT);
		chk(rd, 32'h0);
		settle();
		chk(device_reset_n, 1'b1);
		$display("test mid-run reset done");
		test_done();
	end
endmodule : tb_supply_supervision_control
